// ---- core/dac_evt_pkg.sv ----
package dac_evt_pkg;
   // ==========================================================
   // Sizes
   localparam int NUM_CH = 2;
   localparam int DATA_W = 12;
   localparam int EV_LINES = 2;
   localparam int ADDR_W = 8;
   localparam int CNT_W = 16;
   localparam int FLAG_W = 4;
   // ==========================================================
   // Timing (ns) and derived cycle counts at 100 MHz
   localparam int CLK_NS = 10;
   localparam int STARTUP_NS = 10000;
   localparam int CONV_NS = 1000;
   localparam int STARTUP_CYC = (STARTUP_NS + CLK_NS - 1) / CLK_NS;
   localparam int CONV_CYC = (CONV_NS + CLK_NS - 1) / CLK_NS;
   // ==========================================================
   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_EVCTRL = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_INTERRUPT_ENABLE_CLEAR = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_INTENSET = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_INTERRUPT_FLAG_REGISTER = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_PENDING_VALUE_BUFFER_CH0 = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_DATABUF1 = 8'h1C;
   localparam logic [ADDR_W-1:0] OFS_CONVERSION_VALUE_CH0 = 8'h20;
   localparam logic [ADDR_W-1:0] OFS_DATA1 = 8'h24;
   // ==========================================================
   // Field positions
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int CTRL_RUNSTBY_LSB = 1;
   localparam int EV_STARTEI_LSB = 0;
   localparam int EV_INV_LSB = 2;
   localparam int EV_EMPTYEO_LSB = 4;
   localparam int EV_RESEO_LSB = 6;
   localparam int FLAG_EMPTY_LSB = 0;
   localparam int FLAG_RES_LSB = 2;
   localparam int ST_READY_LSB = 0;
   localparam int ST_BUSY_LSB = 2;
   localparam int ST_FULL_LSB = 4;
   // ==========================================================
   // Reset values
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   // ==========================================================
   // Channel states, Gray coded along off-startup-idle-convert
   typedef enum logic [1:0] {
      CH_OFF = 2'b00,
      CH_STARTUP = 2'b01,
      CH_IDLE = 2'b11,
      CH_CONVERT = 2'b10
   } ch_state_e;
endpackage

// ---- core/start_event_sync.sv ----
`timescale 1ns/10ps
module start_event_sync import dac_evt_pkg::*;
#(
   parameter int LINES = EV_LINES
)
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   input wire logic [LINES-1:0] ev_in,
   input wire logic invert,
   input wire logic enable,
   output logic start_pulse
);
   // ==========================================================
   // Two-stage synchroniser, then edge detect on stage two only
   logic [LINES-1:0] sync1_reg;
   logic [LINES-1:0] sync2_reg;
   logic [LINES-1:0] prev_reg;
   logic [LINES-1:0] level;
   logic [LINES-1:0] prev_next;

   // Raw history is kept, so flipping the invert bit cannot fake an edge
   always_comb
   begin
      prev_next = sync2_reg;
      if (invert)
         level = prev_reg & ~sync2_reg;
      else
         level = sync2_reg & ~prev_reg;
      start_pulse = enable & |level;
   end

   // Only stage two feeds any logic, stage one is metastability room
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         sync1_reg <= '0;
         sync2_reg <= '0;
         prev_reg <= '0;
      end
      else if (ce)
      begin
         sync1_reg <= ev_in;
         sync2_reg <= sync1_reg;
         prev_reg <= prev_next;
      end
   end
endmodule

// ---- core/dac_channel.sv ----
`timescale 1ns/10ps
module dac_channel import dac_evt_pkg::*;
#(
   parameter int DW = DATA_W,
   parameter int STARTUP = STARTUP_CYC,
   parameter int CONV = CONV_CYC
)
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   input wire logic enable,
   input wire logic halt,
   input wire logic auto_start,
   input wire logic buf_write,
   input wire logic [DW-1:0] buf_data,
   input wire logic start_evt,
   output logic [DW-1:0] value,
   output logic buf_full,
   output logic ready,
   output logic busy,
   output logic empty_pulse,
   output logic conv_start
);
   localparam logic [CNT_W-1:0] STARTUP_LAST = CNT_W'(STARTUP - 1);
   localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV - 1);
   ch_state_e state_reg, state_next;
   logic [CNT_W-1:0] cnt_reg, cnt_next;
   logic [DW-1:0] buf_reg, buf_next;
   logic [DW-1:0] value_reg, value_next;
   logic full_reg, full_next;
   logic pend_reg, pend_next;
   logic empty_reg, empty_next;
   logic start_reg, start_next;
   logic go;

   // ==========================================================
   // Channel sequencer
   always_comb
   begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      buf_next = buf_reg;
      value_next = value_reg;
      full_next = full_reg;
      pend_next = pend_reg;
      empty_next = 1'b0;
      start_next = 1'b0;
      go = pend_reg | start_evt | (auto_start & full_reg);
      case (state_reg)
         CH_OFF:
         begin
            pend_next = 1'b0;
            if (enable)
            begin
               state_next = CH_STARTUP;
               cnt_next = STARTUP_LAST;
            end
         end
         CH_STARTUP:
         begin
            // Early event loads the value but never starts
            if (start_evt)
            begin
               value_next = buf_reg;
               full_next = 1'b0;
               empty_next = full_reg;
            end
            if (!enable)
               state_next = CH_OFF;
            else if (cnt_reg == '0)
               state_next = CH_IDLE;
            else
               cnt_next = cnt_reg - 1'b1;
         end
         CH_IDLE:
         begin
            if (!enable)
               state_next = CH_OFF;
            else if (go && !halt)
            begin
               value_next = buf_reg;
               full_next = 1'b0;
               empty_next = full_reg;
               start_next = 1'b1;
               pend_next = 1'b0;
               cnt_next = CONV_LAST;
               state_next = CH_CONVERT;
            end
            else if (start_evt)
               pend_next = 1'b1;
         end
         CH_CONVERT:
         begin
            // Event while busy waits until the channel is ready
            if (start_evt)
               pend_next = 1'b1;
            if (!enable)
               state_next = CH_OFF;
            else if (!halt)
            begin
               if (cnt_reg == '0)
                  state_next = CH_IDLE;
               else
                  cnt_next = cnt_reg - 1'b1;
            end
         end
         default:
            state_next = CH_OFF;
      endcase
      // A write in the load cycle refills the buffer, so it wins
      if (buf_write)
      begin
         buf_next = buf_data;
         full_next = 1'b1;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         state_reg <= CH_OFF;
         cnt_reg <= '0;
         buf_reg <= '0;
         value_reg <= '0;
         full_reg <= 1'b0;
         pend_reg <= 1'b0;
         empty_reg <= 1'b0;
         start_reg <= 1'b0;
      end
      else if (ce)
      begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         buf_reg <= buf_next;
         value_reg <= value_next;
         full_reg <= full_next;
         pend_reg <= pend_next;
         empty_reg <= empty_next;
         start_reg <= start_next;
      end
   end

   assign value = value_reg;
   assign buf_full = full_reg;
   assign ready = (state_reg == CH_IDLE);
   assign busy = (state_reg == CH_CONVERT);
   assign empty_pulse = empty_reg;
   assign conv_start = start_reg;
endmodule

// ---- core/dac_event_ctrl.sv ----
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/10ps
module dac_event_ctrl import dac_evt_pkg::*;
#(
   parameter int DW = DATA_W,
   parameter int LINES = EV_LINES
)
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [LINES-1:0] start_conversion_action_ch0,
   input wire logic [LINES-1:0] start_conversion_action_ch1,
   input wire logic filter_done_ch0,
   input wire logic filter_done_ch1,
   input wire logic standby_sleep,
   output logic buffer_empty_event_ch0,
   output logic buffer_empty_event_ch1,
   output logic filter_result_event_ch0,
   output logic filter_result_event_ch1,
   output logic [DW-1:0] conversion_value_ch0,
   output logic [DW-1:0] conversion_value_ch1,
   output logic conv_start_ch0,
   output logic conv_start_ch1,
   output logic irq
);
   // ==========================================================
   // Register state
   logic enable_reg, enable_next;
   logic [NUM_CH-1:0] standby_run_enable_reg, standby_run_enable_next;
   logic [NUM_CH-1:0] start_event_in_enable_reg, start_event_in_enable_next;
   logic [NUM_CH-1:0] event_edge_invert_reg, event_edge_invert_next;
   logic [NUM_CH-1:0] empty_event_out_enable_reg, empty_event_out_enable_next;
   logic [NUM_CH-1:0] result_event_out_enable_reg, result_event_out_enable_next;
   logic [FLAG_W-1:0] inten_reg, inten_next;
   logic [FLAG_W-1:0] interrupt_flag_register_reg, interrupt_flag_register_next;
   logic irq_reg, irq_next;
   logic [31:0] prdata_reg, prdata_next;
   logic [NUM_CH-1:0] empty_evt_reg, empty_evt_next;
   logic [NUM_CH-1:0] result_evt_reg, result_evt_next;

   // ==========================================================
   // Per-channel wiring
   logic [LINES-1:0] ev_lines [NUM_CH];
   logic [NUM_CH-1:0] filter_done;
   logic [NUM_CH-1:0] start_pulse;
   logic [NUM_CH-1:0] buf_write;
   logic [NUM_CH-1:0] buf_full;
   logic [NUM_CH-1:0] ch_ready;
   logic [NUM_CH-1:0] ch_busy;
   logic [NUM_CH-1:0] empty_pulse;
   logic [NUM_CH-1:0] conv_start;
   logic [DW-1:0] ch_value [NUM_CH];

   // ==========================================================
   // Bus decode signals
   logic setup;
   logic wr;
   logic hit;
   logic [31:0] rdata;
   logic [FLAG_W-1:0] flag_set;
   logic [FLAG_W-1:0] flag_clr;

   assign ev_lines[0] = start_conversion_action_ch0;
   assign ev_lines[1] = start_conversion_action_ch1;
   assign filter_done = {filter_done_ch1, filter_done_ch0};

   // ==========================================================
   // Channels with their event synchronisers
   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++)
      begin : gen_ch
         start_event_sync #(.LINES(LINES)) u_sync
         (
            .clk_sys(clk_sys),
            .rst(rst),
            .ce(ce),
            .ev_in(ev_lines[g]),
            .invert(event_edge_invert_reg[g]),
            .enable(start_event_in_enable_reg[g]),
            .start_pulse(start_pulse[g])
         );
         // Standby halt only bites when the channel may not run asleep
         dac_channel #(.DW(DW)) u_ch
         (
            .clk_sys(clk_sys),
            .rst(rst),
            .ce(ce),
            .enable(enable_reg),
            .halt(standby_sleep & ~standby_run_enable_reg[g]),
            .auto_start(~start_event_in_enable_reg[g]),
            .buf_write(buf_write[g]),
            .buf_data(pwdata[DW-1:0]),
            .start_evt(start_pulse[g]),
            .value(ch_value[g]),
            .buf_full(buf_full[g]),
            .ready(ch_ready[g]),
            .busy(ch_busy[g]),
            .empty_pulse(empty_pulse[g]),
            .conv_start(conv_start[g])
         );
      end
   endgenerate

   // ==========================================================
   // APB phases: zero wait states, read data captured in setup
   assign setup = psel & ~penable;
   assign wr = psel & penable & pwrite;
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~hit;
   assign buf_write[0] = wr & (paddr == OFS_PENDING_VALUE_BUFFER_CH0);
   assign buf_write[1] = wr & (paddr == OFS_DATABUF1);

   // Read mux and address decode
   always_comb
   begin
      rdata = RST_WORD;
      hit = 1'b1;
      if (paddr == OFS_CTRL)
      begin
         rdata[CTRL_ENABLE_BIT] = enable_reg;
         rdata[CTRL_RUNSTBY_LSB +: NUM_CH] = standby_run_enable_reg;
      end
      else if (paddr == OFS_EVCTRL)
      begin
         rdata[EV_STARTEI_LSB +: NUM_CH] = start_event_in_enable_reg;
         rdata[EV_INV_LSB +: NUM_CH] = event_edge_invert_reg;
         rdata[EV_EMPTYEO_LSB +: NUM_CH] = empty_event_out_enable_reg;
         rdata[EV_RESEO_LSB +: NUM_CH] = result_event_out_enable_reg;
      end
      else if (paddr == OFS_INTERRUPT_ENABLE_CLEAR || paddr == OFS_INTENSET)
         rdata[FLAG_W-1:0] = inten_reg;
      else if (paddr == OFS_INTERRUPT_FLAG_REGISTER)
         rdata[FLAG_W-1:0] = interrupt_flag_register_reg;
      else if (paddr == OFS_STATUS)
      begin
         rdata[ST_READY_LSB +: NUM_CH] = ch_ready;
         rdata[ST_BUSY_LSB +: NUM_CH] = ch_busy;
         rdata[ST_FULL_LSB +: NUM_CH] = buf_full;
      end
      else if (paddr == OFS_PENDING_VALUE_BUFFER_CH0 || paddr == OFS_DATABUF1)
         rdata = RST_WORD;
      else if (paddr == OFS_CONVERSION_VALUE_CH0)
         rdata[DW-1:0] = ch_value[0];
      else if (paddr == OFS_DATA1)
         rdata[DW-1:0] = ch_value[1];
      else
         hit = 1'b0;
   end

   // ==========================================================
   // Control register writes
   always_comb
   begin
      enable_next = enable_reg;
      standby_run_enable_next = standby_run_enable_reg;
      start_event_in_enable_next = start_event_in_enable_reg;
      event_edge_invert_next = event_edge_invert_reg;
      empty_event_out_enable_next = empty_event_out_enable_reg;
      result_event_out_enable_next = result_event_out_enable_reg;
      inten_next = inten_reg;
      if (wr && paddr == OFS_CTRL)
      begin
         enable_next = pwdata[CTRL_ENABLE_BIT];
         standby_run_enable_next = pwdata[CTRL_RUNSTBY_LSB +: NUM_CH];
      end
      else if (wr && paddr == OFS_EVCTRL)
      begin
         start_event_in_enable_next = pwdata[EV_STARTEI_LSB +: NUM_CH];
         event_edge_invert_next = pwdata[EV_INV_LSB +: NUM_CH];
         empty_event_out_enable_next = pwdata[EV_EMPTYEO_LSB +: NUM_CH];
         result_event_out_enable_next = pwdata[EV_RESEO_LSB +: NUM_CH];
      end
      else if (wr && paddr == OFS_INTERRUPT_ENABLE_CLEAR)
         inten_next = inten_reg & ~pwdata[FLAG_W-1:0];
      else if (wr && paddr == OFS_INTENSET)
         inten_next = inten_reg | pwdata[FLAG_W-1:0];
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         enable_reg <= 1'b0;
         standby_run_enable_reg <= '0;
         start_event_in_enable_reg <= '0;
         event_edge_invert_reg <= '0;
         empty_event_out_enable_reg <= '0;
         result_event_out_enable_reg <= '0;
         inten_reg <= '0;
      end
      else if (ce)
      begin
         enable_reg <= enable_next;
         standby_run_enable_reg <= standby_run_enable_next;
         start_event_in_enable_reg <= start_event_in_enable_next;
         event_edge_invert_reg <= event_edge_invert_next;
         empty_event_out_enable_reg <= empty_event_out_enable_next;
         result_event_out_enable_reg <= result_event_out_enable_next;
         inten_reg <= inten_next;
      end
   end

   // ==========================================================
   // Flags, request line and output events
   // A set in the clearing cycle wins so no event is lost
   always_comb
   begin
      flag_set = '0;
      flag_set[FLAG_EMPTY_LSB +: NUM_CH] = empty_pulse;
      flag_set[FLAG_RES_LSB +: NUM_CH] = filter_done;
      flag_clr = '0;
      if (wr && paddr == OFS_INTERRUPT_FLAG_REGISTER)
         flag_clr = pwdata[FLAG_W-1:0];
      interrupt_flag_register_next = (interrupt_flag_register_reg & ~flag_clr) | flag_set;
      irq_next = |(interrupt_flag_register_next & inten_next);
      empty_evt_next = empty_pulse & empty_event_out_enable_reg;
      result_evt_next = filter_done & result_event_out_enable_reg;
      prdata_next = setup ? rdata : prdata_reg;
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         interrupt_flag_register_reg <= '0;
         irq_reg <= 1'b0;
         empty_evt_reg <= '0;
         result_evt_reg <= '0;
         prdata_reg <= RST_WORD;
      end
      else if (ce)
      begin
         interrupt_flag_register_reg <= interrupt_flag_register_next;
         irq_reg <= irq_next;
         empty_evt_reg <= empty_evt_next;
         result_evt_reg <= result_evt_next;
         prdata_reg <= prdata_next;
      end
   end

   // ==========================================================
   // Outputs
   assign prdata = prdata_reg;
   assign irq = irq_reg;
   assign buffer_empty_event_ch0 = empty_evt_reg[0];
   assign buffer_empty_event_ch1 = empty_evt_reg[1];
   assign filter_result_event_ch0 = result_evt_reg[0];
   assign filter_result_event_ch1 = result_evt_reg[1];
   assign conversion_value_ch0 = ch_value[0];
   assign conversion_value_ch1 = ch_value[1];
   assign conv_start_ch0 = conv_start[0];
   assign conv_start_ch1 = conv_start[1];
endmodule

// ---- tb/event_fabric_model.sv ----
`timescale 1ns/10ps
module event_fabric_model import dac_evt_pkg::*;
(
   input wire logic clk_sys,
   output logic [EV_LINES-1:0] ev_ch0,
   output logic [EV_LINES-1:0] ev_ch1,
   output logic done_ch0,
   output logic done_ch1
);
   // ==========================================
   // Event fabric lines, all idle low
   initial
   begin
      ev_ch0 = '0;
      ev_ch1 = '0;
      done_ch0 = 1'b0;
      done_ch1 = 1'b0;
   end

   // Level is held three cycles so the synchroniser cannot miss it
   task automatic flip(input int ch, input int ln);
      @(posedge clk_sys);
      if (ch == 0)
         ev_ch0[ln] <= ~ev_ch0[ln];
      else
         ev_ch1[ln] <= ~ev_ch1[ln];
      repeat (3) @(posedge clk_sys);
   endtask

   // Filter completion is a one-cycle synchronous pulse
   task automatic pulse(input int ch);
      @(posedge clk_sys);
      done_ch0 <= (ch == 0);
      done_ch1 <= (ch == 1);
      @(posedge clk_sys);
      done_ch0 <= 1'b0;
      done_ch1 <= 1'b0;
   endtask
endmodule

// ---- tb/dac_event_ctrl_properties.sv ----
`timescale 1ns/10ps
module dac_event_ctrl_chk import dac_evt_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic filter_done_ch0,
   input wire logic filter_done_ch1,
   input wire logic standby_sleep,
   input wire logic buffer_empty_event_ch0,
   input wire logic filter_result_event_ch0,
   input wire logic filter_result_event_ch1,
   input wire logic conv_start_ch0,
   input wire logic irq
);
   // ==========================================
   // Shadow copies of the control bits, rebuilt from bus writes
   logic wr;
   logic [7:0] evq;
   logic [3:0] ienq;
   logic [2:0] ctlq;
   assign wr = psel && penable && pwrite && pready && ce;
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         evq <= '0;
         ienq <= '0;
         ctlq <= '0;
      end
      else if (wr)
      begin
         if (paddr == OFS_EVCTRL)
            evq <= pwdata[7:0];
         if (paddr == OFS_CTRL)
            ctlq <= pwdata[2:0];
         if (paddr == OFS_INTENSET)
            ienq <= ienq | pwdata[3:0];
         if (paddr == OFS_INTERRUPT_ENABLE_CLEAR)
            ienq <= ienq & ~pwdata[3:0];
      end
   end

   // ==========================================
   // Properties
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   sequence s_irq_low;
      ##[1:2] !irq;
   endsequence
   sequence s_quiet;
      (!conv_start_ch0) [*8];
   endsequence

   a_result_follows: assert property (ce && filter_done_ch0 && evq[6] |=> filter_result_event_ch0)
      else $error("result event missing");
   a_result_gated: assert property (ce && filter_done_ch1 && !evq[7] |=> !filter_result_event_ch1)
      else $error("result event not gated");
   a_empty_gated: assert property (buffer_empty_event_ch0 |-> $past(evq[4]))
      else $error("empty event not gated");
   a_empty_on_start: assert property (conv_start_ch0 && evq[4] |-> ##1 buffer_empty_event_ch0)
      else $error("empty event missing");
   a_start_one_shot: assert property (conv_start_ch0 |=> s_quiet)
      else $error("start pulse repeated");
   a_irq_on_result: assert property (filter_result_event_ch0 && ienq[2] |-> ##[0:1] irq)
      else $error("irq missing on result");
   a_irq_on_empty: assert property (buffer_empty_event_ch0 && ienq[0] |-> ##[0:1] irq)
      else $error("irq missing on empty");
   a_irq_fall_cause: assert property ($fell(irq) |-> $past(wr) || $past(wr, 2))
      else $error("irq fell without write");
   a_enclr_drop: assert property (wr && paddr == OFS_INTERRUPT_ENABLE_CLEAR && (ienq & ~pwdata[3:0]) == 4'h0
      |-> s_irq_low)
      else $error("irq stays after enable clear");
   a_flag_clear: assert property (wr && paddr == OFS_INTERRUPT_FLAG_REGISTER && pwdata[3:0] == 4'hF
      |-> s_irq_low)
      else $error("irq stays after flag clear");
   a_halt_sleep: assert property (standby_sleep && $past(standby_sleep) && !ctlq[1]
      |-> !conv_start_ch0)
      else $error("conversion while halted");
endmodule

bind dac_event_ctrl dac_event_ctrl_chk chk_u
(
   .clk_sys, .rst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
   .filter_done_ch0, .filter_done_ch1, .standby_sleep, .buffer_empty_event_ch0,
   .filter_result_event_ch0, .filter_result_event_ch1, .conv_start_ch0, .irq
);

// ---- tb/dac_event_ctrl_tb.sv ----
`timescale 1ns/10ps
module dac_event_ctrl_tb import dac_evt_pkg::*; ;
   // ==========================================
   // Signals and scoreboard
   logic clk_sys, rst, ce, psel, penable, pwrite, standby_sleep;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata;
   logic pready, pslverr, be0, be1, fr0, fr1, cs0, cs1, irq, fd0, fd1;
   logic [EV_LINES-1:0] ev0, ev1;
   logic [11:0] v;
   logic [DATA_W-1:0] cv0, cv1;
   logic [32:0] rq[$];
   logic [5:0] evq[$];
   int num_errors = 0;
   int check_count = 0;

   dac_event_ctrl dut_u
   (
      .clk_sys, .rst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .start_conversion_action_ch0(ev0), .start_conversion_action_ch1(ev1),
      .filter_done_ch0(fd0), .filter_done_ch1(fd1), .standby_sleep,
      .buffer_empty_event_ch0(be0), .buffer_empty_event_ch1(be1),
      .filter_result_event_ch0(fr0), .filter_result_event_ch1(fr1),
      .conversion_value_ch0(cv0), .conversion_value_ch1(cv1),
      .conv_start_ch0(cs0), .conv_start_ch1(cs1), .irq
   );
   event_fabric_model ev_u
   (
      .clk_sys, .ev_ch0(ev0), .ev_ch1(ev1), .done_ch0(fd0), .done_ch1(fd1)
   );

   // 100 MHz clock
   initial
   begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   // ==========================================
   // Compare and report
   task automatic print_verdict();
      if (num_errors == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk_sig(input string n, input logic [32:0] e, input logic [32:0] g);
      check_count++;
      if (g !== e)
      begin
         num_errors++;
         $display("wrong value %s exp %h got %h", n, e, g);
      end
   endtask

   // Bus cycle; the request holds until pready is seen high
   task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
      int i;
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      i = 0;
      do
         @(posedge clk_sys);
      while (pready !== 1'b1 && ++i < 50);
      psel <= 1'b0;
      penable <= 1'b0;
      if (i >= 50)
      begin
         num_errors++;
         print_verdict();
      end
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [32:0] e);
      rq.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   // Bounded wait until every noted event has shown up
   task automatic drain();
      for (int i = 0; i < 300 && evq.size() > 0; i++)
         @(posedge clk_sys);
      if (evq.size() > 0)
      begin
         chk_sig("missing_events", 33'h0, 33'(evq.size()));
         print_verdict();
      end
   endtask
   task automatic irq_is(input logic e);
      repeat (3) @(posedge clk_sys);
      chk_sig("irq", {32'h0, e}, {32'h0, irq});
   endtask

   // Watcher: every read and every event pulse takes the oldest note
   always @(posedge clk_sys)
   begin
      if (!rst && psel && penable && pready && !pwrite)
         chk_sig("prdata", rq.size() > 0 ? rq.pop_front() : 'x, {pslverr, prdata});
      if (!rst && {fr1, fr0, be1, be0, cs1, cs0} !== 6'h00)
         chk_sig("events", evq.size() > 0 ? 33'(evq.pop_front()) : 'x,
            33'({fr1, fr0, be1, be0, cs1, cs0}));
   end

   // Overall limit on run length
   initial
   begin
      repeat (60000) @(posedge clk_sys);
      num_errors++;
      print_verdict();
   end

   // ==========================================
   // Main sequence
   initial
   begin
      {rst, ce, psel, penable, pwrite, standby_sleep} = 6'b110000;
      paddr = '0;
      pwdata = '0;
      v = 12'($urandom(28213));
      repeat (16) @(posedge clk_sys);
      rst <= 1'b0;
      rd(OFS_EVCTRL, 33'h0);
      rd(OFS_INTERRUPT_FLAG_REGISTER, 33'h0);
      rd(8'h30, {1'b1, 32'h0});
      wr(OFS_EVCTRL, 32'h5B);
      wr(OFS_CTRL, 32'h5);
      // Event inside startup: data loads, no conversion starts
      v = 12'($urandom);
      wr(OFS_PENDING_VALUE_BUFFER_CH0, {20'h0, v});
      evq.push_back(6'h04);
      ev_u.flip(0, 1);
      drain();
      rd(OFS_CONVERSION_VALUE_CH0, {21'h0, v});
      chk_sig("conversion_value_ch0", {21'h0, v}, {21'h0, cv0});
      repeat (STARTUP_CYC) @(posedge clk_sys);
      v = 12'($urandom);
      wr(OFS_PENDING_VALUE_BUFFER_CH0, {20'h0, v});
      evq.push_back(6'h01);
      evq.push_back(6'h04);
      ev_u.flip(0, 0);
      drain();
      rd(OFS_CONVERSION_VALUE_CH0, {21'h0, v});
      // Inverted channel: rise ignored, fall starts; empty event gated
      v = 12'($urandom);
      wr(OFS_DATABUF1, {20'h0, v});
      ev_u.flip(1, 0);
      repeat (20) @(posedge clk_sys);
      evq.push_back(6'h02);
      ev_u.flip(1, 0);
      drain();
      rd(OFS_DATA1, {21'h0, v});
      chk_sig("conversion_value_ch1", {21'h0, v}, {21'h0, cv1});
      repeat (CONV_CYC + 10) @(posedge clk_sys);
      evq.push_back(6'h10);
      ev_u.pulse(0);
      ev_u.pulse(1);
      drain();
      // Interrupt flags, enables and the merged line
      wr(OFS_INTERRUPT_FLAG_REGISTER, 32'hF);
      rd(OFS_INTERRUPT_FLAG_REGISTER, 33'h0);
      wr(OFS_INTENSET, 32'h4);
      evq.push_back(6'h10);
      ev_u.pulse(0);
      drain();
      irq_is(1'b1);
      rd(OFS_INTERRUPT_FLAG_REGISTER, 33'h4);
      wr(OFS_INTERRUPT_FLAG_REGISTER, 32'h0);
      wr(OFS_INTERRUPT_ENABLE_CLEAR, 32'h0);
      irq_is(1'b1);
      wr(OFS_INTERRUPT_ENABLE_CLEAR, 32'h4);
      irq_is(1'b0);
      wr(OFS_INTENSET, 32'h4);
      irq_is(1'b1);
      wr(OFS_INTERRUPT_FLAG_REGISTER, 32'h4);
      irq_is(1'b0);
      // Standby: channel 1 keeps running, channel 0 waits for wake-up
      wr(OFS_INTENSET, 32'h1);
      standby_sleep <= 1'b1;
      wr(OFS_DATABUF1, {20'h0, 12'($urandom)});
      ev_u.flip(1, 1);
      evq.push_back(6'h02);
      ev_u.flip(1, 1);
      drain();
      wr(OFS_PENDING_VALUE_BUFFER_CH0, {20'h0, 12'($urandom)});
      ev_u.flip(0, 0);
      ev_u.flip(0, 0);
      repeat (30) @(posedge clk_sys);
      evq.push_back(6'h01);
      evq.push_back(6'h04);
      standby_sleep <= 1'b0;
      drain();
      irq_is(1'b1);
      wr(OFS_INTERRUPT_FLAG_REGISTER, 32'hF);
      irq_is(1'b0);
      // Clock enable low freezes the block, so this write is lost
      ce <= 1'b0;
      wr(OFS_INTENSET, 32'h2);
      ce <= 1'b1;
      rd(OFS_INTENSET, 33'h5);
      // Reset in mid-run returns the control bits to zero
      rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      rd(OFS_EVCTRL, 33'h0);
      // Input events off: a written buffer converts on its own
      wr(OFS_CTRL, 32'h1);
      repeat (STARTUP_CYC + 2) @(posedge clk_sys);
      evq.push_back(6'h01);
      wr(OFS_PENDING_VALUE_BUFFER_CH0, {20'h0, v});
      drain();
      chk_sig("conversion_value_ch0", {21'h0, v}, {21'h0, cv0});
      repeat (4) @(posedge clk_sys);
      print_verdict();
   end
endmodule
